// file: timer_defs.svh
// How it works
// - event mode counts each chosen edge of the event pin; select 00H falling, 01H rising.
// - clear-and-start mode clears counter on compare match and pulses the match interrupt.
// - square-wave mode inverts the output flip-flop on every compare match.
// - square-wave frequency is 1/(2t(N+1)) for compare N from 00H to FFH.
// - level-set gives high, level-clear gives low initial output flip-flop.
// - mode bit 6 selects free-running PWM; compare sets active width.
// - in PWM, mode bit 1 low means active-high, high means active-low.
// - mode bit 0 enables the output pin in square-wave and PWM operation.
// - clock-select bits 0 to 2 choose the count clock.
// - PWM output inactive until first overflow, active until match, then inactive.
// - clearing count-run in PWM mode forces the output inactive.
// - PWM period is 256 count clocks, active width N, duty N/256.
// - PWM compare write before the FFH edge takes effect next overflow, else second.
// - compare reads return the written value while the old one still governs output.
// - level-set and level-clear are ignored in PWM mode.
// - first match after start may come up to one count clock early.
// - clearing count-run stops and zeroes the counter; setting it starts counting.
// - level-set and level-clear read as zero; both set together is ignored.
// - mode and output settings reach the pin whether or not counting runs.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define OFS_MODE_CONTROL   8'h00
`define OFS_CLOCK_SELECT   8'h04
`define OFS_COMPARE_VALUE  8'h08
`define OFS_COUNTER_VALUE  8'h0C

`define BIT_COUNT_RUN      7
`define BIT_PWM_MODE       6
`define BIT_LEVEL_SET      3
`define BIT_LEVEL_CLEAR    2
`define BIT_INV_POLARITY   1
`define BIT_OUTPUT_ENABLE  0

`define RST_BYTE           8'h00
`define COUNT_TOP          8'hFF

`define SEL_EDGE_FALL      3'h0
`define SEL_EDGE_RISE      3'h1
`define DIV_2_LAST         10'h001
`define DIV_4_LAST         10'h003
`define DIV_16_LAST        10'h00F
`define DIV_64_LAST        10'h03F
`define DIV_256_LAST       10'h0FF
`define DIV_1024_LAST      10'h3FF

`endif

// file: timer_pkg.sv
package timer_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] clk_sel_t;
endpackage

// file: count_clock_gen.sv
`timescale 1ns/1ns
`include "timer_defs.svh"
module count_clock_gen (
    input  wire logic              mclk,          // system clock
    input  wire logic              rstn,          // synchronised reset, active low
    input  wire timer_pkg::clk_sel_t sel,         // count clock choice
    input  wire logic              eventInPin,    // event input pin level
    output logic                   tick           // one-cycle count enable
);
    import timer_pkg::*;

    typedef struct packed {
        logic [9:0] div;
        logic       evPrev;
        logic       tick;
    } gen_state_t;

    gen_state_t s_q;
    gen_state_t s_d;

    always_comb begin
        logic [9:0] last;
        last = `DIV_2_LAST;
        s_d = s_q;
        s_d.div = s_q.div + 10'h001;
        s_d.evPrev = eventInPin;
        unique case (sel)
            3'h2: last = `DIV_2_LAST;
            3'h3: last = `DIV_4_LAST;
            3'h4: last = `DIV_16_LAST;
            3'h5: last = `DIV_64_LAST;
            3'h6: last = `DIV_256_LAST;
            3'h7: last = `DIV_1024_LAST;
            default: last = `DIV_2_LAST;
        endcase
        if (sel == `SEL_EDGE_FALL) begin
            s_d.tick = s_q.evPrev & ~eventInPin;
        end else if (sel == `SEL_EDGE_RISE) begin
            s_d.tick = ~s_q.evPrev & eventInPin;
        end else begin
            // divider runs free of count_run, so the first tick after start may come up to one count clock early
            s_d.tick = ((s_q.div & last) == last);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule // count_clock_gen

// file: timer_event_counter_8bit.sv
`timescale 1ns/1ns
`include "timer_defs.svh"
module timer_event_counter_8bit (
    input  wire logic        mclk,            // system clock, 50 MHz
    input  wire logic        rstn,            // asynchronous reset, active low
    input  wire logic        wb_cyc_i,        // wishbone cycle
    input  wire logic        wb_stb_i,        // wishbone strobe
    input  wire logic        wb_we_i,         // wishbone write enable
    input  wire logic [7:0]  wb_adr_i,        // wishbone byte address
    input  wire logic [31:0] wb_dat_i,        // wishbone write data
    input  wire logic [3:0]  wb_sel_i,        // wishbone byte selects
    output logic      [31:0] wb_dat_o,        // wishbone read data
    output logic             wb_ack_o,        // wishbone acknowledge
    input  wire logic        eventInputPin,   // external event pulses
    output logic             timerOutputPin,  // timer output level
    output logic             matchInterrupt   // one-cycle match pulse
);
    import timer_pkg::*;

    typedef struct packed {
        logic      countRun;
        logic      pwmModeSelect;
        logic      inversionOrPolarity;
        logic      outputPinEnable;
        clk_sel_t  countClockSelect;
        byte_t     compareValue;       // value software sees
        byte_t     activeCompare;      // value that governs the counter
        logic      transferPending;
        logic      transferArmed;
        byte_t     eventCounterValue;
        logic      outFf;
        logic      pwmActive;
        logic      ack;
        logic [31:0] rdata;
        logic      pin;
        logic      irq;
    } timer_state_t;

    timer_state_t s_q;
    timer_state_t s_d;
    logic         rstSync1_q;
    logic         rstSync2_q;
    logic         tick;

    // reset release through two flip-flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end

    count_clock_gen u_clk (
        .mclk       (mclk),
        .rstn       (rstSync2_q),
        .sel        (s_q.countClockSelect),
        .eventInPin (eventInputPin),
        .tick       (tick)
    );

    always_comb begin
        logic  req;
        logic  wr;
        byte_t wd;
        logic  runTick;
        byte_t nextCount;
        logic  lvSet;
        logic  lvClr;
        logic  pinLevel;
        req = 1'b0;
        wr = 1'b0;
        wd = `RST_BYTE;
        runTick = 1'b0;
        nextCount = `RST_BYTE;
        lvSet = 1'b0;
        lvClr = 1'b0;
        pinLevel = 1'b0;
        s_d = s_q;
        s_d.irq = 1'b0;

        req = wb_cyc_i & wb_stb_i & ~s_q.ack;
        wr = req & wb_we_i & wb_sel_i[0];
        wd = wb_dat_i[7:0];
        s_d.ack = req;

        // register reads; level-set and level-clear always read back as zero
        s_d.rdata = 32'h0000_0000;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                `OFS_MODE_CONTROL: s_d.rdata[7:0] = {s_q.countRun, s_q.pwmModeSelect, 4'h0,
                                                     s_q.inversionOrPolarity, s_q.outputPinEnable};
                `OFS_CLOCK_SELECT: s_d.rdata[2:0] = s_q.countClockSelect;
                `OFS_COMPARE_VALUE: s_d.rdata[7:0] = s_q.compareValue;
                `OFS_COUNTER_VALUE: s_d.rdata[7:0] = s_q.eventCounterValue;
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // counting on the selected count clock
        runTick = tick & s_q.countRun;
        if (runTick) begin
            if (s_q.pwmModeSelect) begin
                nextCount = s_q.eventCounterValue + 8'h01;
                s_d.eventCounterValue = nextCount;
                if (s_q.eventCounterValue == `COUNT_TOP) begin
                    // overflow: new period, buffered compare may transfer
                    if (s_q.transferArmed) begin
                        s_d.activeCompare = s_q.compareValue;
                        s_d.transferPending = 1'b0;
                        s_d.transferArmed = 1'b0;
                        s_d.pwmActive = (s_q.compareValue != 8'h00);
                    end else begin
                        s_d.pwmActive = (s_q.activeCompare != 8'h00);
                    end
                end else begin
                    if (nextCount == s_q.activeCompare) begin
                        s_d.pwmActive = 1'b0;
                    end
                    if (nextCount == `COUNT_TOP && s_q.transferPending) begin
                        s_d.transferArmed = 1'b1;
                    end
                end
            end else if (s_q.eventCounterValue == s_q.activeCompare) begin
                s_d.eventCounterValue = `RST_BYTE;
                s_d.irq = 1'b1;
                if (s_q.inversionOrPolarity) begin
                    s_d.outFf = ~s_q.outFf;
                end
            end else begin
                s_d.eventCounterValue = s_q.eventCounterValue + 8'h01;
            end
        end

        // register writes
        if (wr) begin
            unique case (wb_adr_i)
                `OFS_MODE_CONTROL: begin
                    s_d.countRun = wd[`BIT_COUNT_RUN];
                    s_d.pwmModeSelect = wd[`BIT_PWM_MODE];
                    s_d.inversionOrPolarity = wd[`BIT_INV_POLARITY];
                    s_d.outputPinEnable = wd[`BIT_OUTPUT_ENABLE];
                    lvSet = wd[`BIT_LEVEL_SET];
                    lvClr = wd[`BIT_LEVEL_CLEAR];
                    if (!wd[`BIT_PWM_MODE]) begin
                        if (lvSet && !lvClr) begin
                            s_d.outFf = 1'b1;
                        end else if (lvClr && !lvSet) begin
                            s_d.outFf = 1'b0;
                        end
                    end
                    if (!wd[`BIT_COUNT_RUN]) begin
                        s_d.eventCounterValue = `RST_BYTE;
                        s_d.pwmActive = 1'b0;
                        s_d.transferArmed = 1'b0;
                        if (s_q.transferPending) begin
                            s_d.activeCompare = s_q.compareValue;
                            s_d.transferPending = 1'b0;
                        end
                    end
                end
                `OFS_CLOCK_SELECT: s_d.countClockSelect = wd[2:0];
                `OFS_COMPARE_VALUE: begin
                    s_d.compareValue = wd;
                    if (s_q.pwmModeSelect && s_q.countRun) begin
                        s_d.transferPending = 1'b1;
                        s_d.transferArmed = 1'b0;
                    end else begin
                        s_d.activeCompare = wd;
                    end
                end
                default: begin
                end
            endcase
        end

        // pin follows the settings whether counting or not
        if (s_d.pwmModeSelect) begin
            pinLevel = s_d.pwmActive ^ s_d.inversionOrPolarity;
        end else begin
            pinLevel = s_d.outFf;
        end
        s_d.pin = s_d.outputPinEnable & pinLevel;
    end

    always_ff @(posedge mclk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;
    assign timerOutputPin = s_q.pin;
    assign matchInterrupt = s_q.irq;
endmodule // timer_event_counter_8bit

// file: event_source_model.sv
`timescale 1ns/1ns
module event_source_model (
    input  wire logic mclk,      // system clock
    output logic      eventLine  // event pulses, idle low
);
    initial eventLine = 1'b0;
    // each level is held for several clocks so both edges are seen
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge mclk);
            eventLine <= 1'b1;
            repeat (3) @(posedge mclk);
            eventLine <= 1'b0;
            repeat (2) @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
    endtask
endmodule // event_source_model

// file: timer_event_counter_8bit_assertions.sv
`timescale 1ns/1ns
`include "timer_defs.svh"
module timer_event_counter_8bit_assertions (
    input wire logic        mclk,           // system clock
    input wire logic        rstn,           // reset, active low
    input wire logic        wb_cyc_i,       // cycle
    input wire logic        wb_stb_i,       // strobe
    input wire logic        wb_we_i,        // write enable
    input wire logic [7:0]  wb_adr_i,       // address
    input wire logic [31:0] wb_dat_i,       // write data
    input wire logic [3:0]  wb_sel_i,       // byte selects
    input wire logic [31:0] wb_dat_o,       // read data
    input wire logic        wb_ack_o,       // acknowledge
    input wire logic        eventInputPin,  // event pin
    input wire logic        timerOutputPin, // output pin
    input wire logic        matchInterrupt  // match pulse
);
    logic [7:0] modeQ;
    logic [7:0] cmpQ;
    logic       rdAck;
    // shadow of the written settings
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            modeQ <= 8'h00;
            cmpQ  <= 8'h00;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `OFS_MODE_CONTROL) modeQ <= wb_dat_i[7:0];
            if (wb_adr_i == `OFS_COMPARE_VALUE) cmpQ <= wb_dat_i[7:0];
        end
    end
    assign rdAck = wb_ack_o && !wb_we_i;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_irq_pulse; matchInterrupt |=> !matchInterrupt; endproperty
    property p_irq_mode; modeQ[6] [*3] |-> !matchInterrupt; endproperty
    property p_irq_run; !modeQ[7] [*3] |-> !matchInterrupt; endproperty
    property p_out_off; !modeQ[0] [*3] |-> !timerOutputPin; endproperty
    property p_pwm_idle; (modeQ[6] && !modeQ[7] && modeQ[0]) [*3] |-> timerOutputPin == modeQ[1]; endproperty
    property p_level_read; rdAck && wb_adr_i == `OFS_MODE_CONTROL |-> wb_dat_o[3:2] == 2'b00; endproperty
    property p_cmp_read; rdAck && wb_adr_i == `OFS_COMPARE_VALUE |-> wb_dat_o == {24'h000000, cmpQ}; endproperty
    property p_cnt_stop;
        rdAck && wb_adr_i == `OFS_COUNTER_VALUE && !modeQ[7] && !$past(modeQ[7]) |-> wb_dat_o == 32'h0;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack missing after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_irq_pulse: assert property (p_irq_pulse) else $error("match pulse too long");
    a_irq_mode: assert property (p_irq_mode) else $error("match pulse in pwm mode");
    a_irq_run: assert property (p_irq_run) else $error("match pulse while stopped");
    a_out_off: assert property (p_out_off) else $error("pin high while disabled");
    a_pwm_idle: assert property (p_pwm_idle) else $error("stopped pwm not inactive");
    a_level_read: assert property (p_level_read) else $error("level bits read nonzero");
    a_cmp_read: assert property (p_cmp_read) else $error("compare readback wrong");
    a_cnt_stop: assert property (p_cnt_stop) else $error("stopped counter nonzero");
    c_irq: cover property (matchInterrupt);
    c_pwm_on: cover property (modeQ[6] && modeQ[7] && timerOutputPin);
    c_read: cover property (rdAck);
endmodule // timer_event_counter_8bit_assertions
bind timer_event_counter_8bit timer_event_counter_8bit_assertions i_chk (.mclk(mclk), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .eventInputPin(eventInputPin),
    .timerOutputPin(timerOutputPin), .matchInterrupt(matchInterrupt));

// file: timer_event_counter_8bit_tb_top.sv
`timescale 1ns/1ns
`include "timer_defs.svh"
module timer_event_counter_8bit_tb_top;
    import timer_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        evt;
    logic        pin;
    logic        irq;
    int          numErrors = 0;
    int          nCompared = 0;
    int          irqCount = 0;
    int          base;
    int          w;
    logic [31:0] rd;
    always #10 mclk = ~mclk;
    always @(posedge mclk) if (irq === 1'b1) irqCount <= irqCount + 1;
    timer_event_counter_8bit i_timer_event_counter_8bit (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
        .wb_ack_o(ack), .eventInputPin(evt), .timerOutputPin(pin), .matchInterrupt(irq));
    event_source_model i_event_source_model (.mclk(mclk), .eventLine(evt));
    task automatic results();
        $display("errors %0d of %0d compared", numErrors, nCompared);
        if (numErrors == 0 && nCompared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic checkCycles(input string name, input int exp, input int got);
        nCompared++;
        if (got != exp) begin
            numErrors++;
            $display("[ERR] %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input byte_t d);
        int k;
        @(posedge mclk);
        {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, wr, a, 24'h000000, d, 4'hF};
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'b1 && k < 16);
        rd = rdat;
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1) begin
            numErrors++;
            results();
        end
    endtask
    task automatic rdChk(input string name, input logic [7:0] a, input byte_t exp);
        xfer(1'b0, a, 8'h00);
        check(name, {24'h000000, exp}, rd);
    endtask
    task automatic pinChk(input string name, input logic exp);
        repeat (4) @(posedge mclk);
        check(name, {31'h0, exp}, {31'h0, pin});
    endtask
    // length of one whole segment of the pin at the given level
    task automatic halfWidth(input logic lvl, output int n);
        int k;
        k = 0;
        n = 0;
        while (pin !== ~lvl && k < 2000) begin
            @(posedge mclk);
            k++;
        end
        while (pin !== lvl && k < 2000) begin
            @(posedge mclk);
            k++;
        end
        while (pin === lvl && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        if (k >= 2000 || n >= 2000) begin
            numErrors++;
            results();
        end
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 5; i++) rdChk("reset value", 8'(i * 4), 8'h00);
        for (int e = 0; e < 2; e++) begin
            xfer(1'b1, `OFS_CLOCK_SELECT, 8'(e));
            xfer(1'b1, `OFS_COMPARE_VALUE, 8'hFF);
            xfer(1'b1, `OFS_MODE_CONTROL, 8'h80);
            i_event_source_model.pulses(5);
            rdChk("event count", `OFS_COUNTER_VALUE, 8'h05);
            xfer(1'b1, `OFS_MODE_CONTROL, 8'h00);
            rdChk("stopped count", `OFS_COUNTER_VALUE, 8'h00);
        end
        xfer(1'b1, `OFS_COMPARE_VALUE, 8'h03);
        base = irqCount;
        xfer(1'b1, `OFS_MODE_CONTROL, 8'h80);
        i_event_source_model.pulses(6);
        checkCycles("match pulses", 1, irqCount - base);
        rdChk("count after match", `OFS_COUNTER_VALUE, 8'h02);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'h00);
        xfer(1'b1, `OFS_CLOCK_SELECT, 8'h02);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'h0B);
        pinChk("level set", 1'b1);
        rdChk("mode readback", `OFS_MODE_CONTROL, 8'h03);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'h07);
        pinChk("level clear", 1'b0);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'h83);
        halfWidth(1'b1, w);
        checkCycles("square high", 8, w);
        halfWidth(1'b0, w);
        checkCycles("square low", 8, w);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'h00);
        xfer(1'b1, `OFS_COMPARE_VALUE, 8'h40);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'h41);
        pinChk("pwm idle", 1'b0);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'h49);
        pinChk("pwm level set", 1'b0);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'hC1);
        halfWidth(1'b1, w);
        checkCycles("pwm active", 128, w);
        halfWidth(1'b0, w);
        checkCycles("pwm inactive", 384, w);
        xfer(1'b1, `OFS_COMPARE_VALUE, 8'h20);
        rdChk("compare pending", `OFS_COMPARE_VALUE, 8'h20);
        halfWidth(1'b1, w);
        checkCycles("pwm new active", 64, w);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'h00);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'h43);
        pinChk("active low idle", 1'b1);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'hC3);
        halfWidth(1'b0, w);
        checkCycles("active low width", 64, w);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'h43);
        pinChk("pwm stopped", 1'b1);
        xfer(1'b1, `OFS_MODE_CONTROL, 8'h42);
        pinChk("output disabled", 1'b0);
        xfer(1'b1, 8'h10, 8'hAA);
        rdChk("unmapped", 8'h10, 8'h00);
        results();
    end
endmodule // timer_event_counter_8bit_tb_top
